// ---- hw/omc_ctrl.sv ----
// Optical module control, fault latch, status pins and identification access
//
// Function
// - Laser-off request high turns the laser off within the assert latency.
// - Laser-off request is active high; an undriven pin reads as a request.
// - Signal-lost output follows the received-power-below-threshold condition.
// - Fault output asserts on laser driver failure or laser end of life.
// - Any fault turns the laser off regardless of the laser-off request.
// - Faults latch; a long laser-off request followed by release clears them.
// - Status outputs are open-drain: pull low or release, never drive high.
// - Presence pin is held at ground by the module.
// - Host drives the serial clock; serial data is shared two-way.
// - Serial interface returns identification data and live diagnostic readings.
// - Laser output drops within 10 us of the request rising edge.
// - Fault output asserts within 100 us of the fault condition.
// - Initialisation finishes within 300 ms of power-on or fault clear.
`timescale 1ns/1ps
`default_nettype none

module omc_ctrl #(
   parameter int unsigned INIT_CYCLES = omc_pkg::INIT_CYC,
   parameter int unsigned HOLD_CYCLES = omc_pkg::RESET_HOLD_CYC
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Laser control
   input  wire logic        laser_off_req,
   output logic             laser_enable,
   // Analogue condition detectors
   input  wire logic        laser_drv_fail,
   input  wire logic        laser_end_of_life,
   input  wire logic        signal_absent_condition,
   // Live diagnostic readings
   input  wire logic [15:0] temp_reading,
   input  wire logic [15:0] supply_reading,
   input  wire logic [15:0] bias_reading,
   input  wire logic [15:0] tx_power_reading,
   input  wire logic [15:0] rx_power_reading,
   // Open-drain status pins
   output logic             laser_fault_o,
   output logic             laser_fault_oe_n,
   output logic             rx_signal_lost_o,
   output logic             rx_signal_lost_oe_n,
   output logic             module_present_ground_o,
   output logic             module_present_ground_oe_n,
   // Two-wire identification pins
   input  wire logic        id_serial_clock,
   input  wire logic        id_serial_data_i,
   output logic             id_serial_data_o,
   output logic             id_serial_data_oe_n
);

   localparam int unsigned INIT_W = $clog2(INIT_CYCLES + 1);
   localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);

   // Three-stage synchronisers; a level is taken once stages two and three agree
   logic [omc_pkg::SYN_N-1:0] syn1_r;
   logic [omc_pkg::SYN_N-1:0] syn2_r;
   logic [omc_pkg::SYN_N-1:0] syn3_r;
   logic [omc_pkg::SYN_N-1:0] filt_r;
   wire  [omc_pkg::SYN_N-1:0] pin_in = {id_serial_data_i, id_serial_clock,
                                        signal_absent_condition, laser_end_of_life,
                                        laser_drv_fail, laser_off_req};

   genvar gi;
   generate
      for (gi = 0; gi < omc_pkg::SYN_N; gi++) begin : g_syn
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               syn1_r[gi] <= omc_pkg::SYN_RST[gi];
               syn2_r[gi] <= omc_pkg::SYN_RST[gi];
               syn3_r[gi] <= omc_pkg::SYN_RST[gi];
               filt_r[gi] <= omc_pkg::SYN_RST[gi];
            end else begin
               syn1_r[gi] <= pin_in[gi];
               syn2_r[gi] <= syn1_r[gi];
               syn3_r[gi] <= syn2_r[gi];
               if (syn2_r[gi] == syn3_r[gi]) begin
                  filt_r[gi] <= syn3_r[gi];
               end
            end
         end
      end
   endgenerate

   // Pad pull-up resolves a floating request pin to high
   wire off_req   = filt_r[omc_pkg::SYN_TXOFF];
   wire fault_now = filt_r[omc_pkg::SYN_DRV] | filt_r[omc_pkg::SYN_EOL];
   wire los_now   = filt_r[omc_pkg::SYN_LOS];

   // Fault latch, clear qualification and initialisation
   omc_pkg::omc_st_e st_r;
   omc_pkg::omc_st_e st_nxt;
   logic              fault_lat_r;
   logic              fault_lat_nxt;
   logic              off_req_d_r;
   logic [HOLD_W-1:0] hold_cnt_r;
   logic [INIT_W-1:0] init_cnt_r;
   logic [INIT_W-1:0] init_cnt_nxt;

   wire hold_met   = (hold_cnt_r == HOLD_W'(HOLD_CYCLES));
   wire req_fall   = off_req_d_r & ~off_req;
   wire fault_clr  = req_fall & hold_met & fault_lat_r;
   wire init_done  = (init_cnt_r == INIT_W'(INIT_CYCLES - 1));

   // New fault wins over a clear in the same cycle
   assign fault_lat_nxt = fault_now | (fault_lat_r & ~fault_clr);

   always_comb begin
      st_nxt       = st_r;
      init_cnt_nxt = init_cnt_r;
      unique case (st_r)
         omc_pkg::ST_INIT: begin
            init_cnt_nxt = init_cnt_r + INIT_W'(1);
            if (init_done) begin
               st_nxt       = omc_pkg::ST_RUN;
               init_cnt_nxt = '0;
            end
         end
         omc_pkg::ST_RUN: begin
            init_cnt_nxt = '0;
         end
      endcase
      if (fault_clr) begin
         st_nxt       = omc_pkg::ST_INIT;
         init_cnt_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r        <= omc_pkg::ST_INIT;
         init_cnt_r  <= '0;
         fault_lat_r <= 1'b0;
         off_req_d_r <= 1'b1;
      end else begin
         st_r        <= st_nxt;
         init_cnt_r  <= init_cnt_nxt;
         fault_lat_r <= fault_lat_nxt;
         off_req_d_r <= off_req;
      end
   end

   // Counts how long the request has been held high, saturating
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_r <= '0;
      end else if (!off_req) begin
         hold_cnt_r <= '0;
      end else if (!hold_met) begin
         hold_cnt_r <= hold_cnt_r + HOLD_W'(1);
      end
   end

   // Laser runs only when not requested off, not faulted and initialised
   wire laser_on_nxt = ~off_req & ~fault_lat_nxt & (st_r == omc_pkg::ST_RUN);

   // Open-drain pins: release (oe_n high) shows a high level via host pull-up
   logic pad_low_r;
   logic laser_en_r;
   logic fault_oe_n_r;
   logic los_oe_n_r;
   logic present_oe_n_r;
   logic sda_oe_n_r;
   logic sda_pull;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_low_r      <= 1'b0;
         laser_en_r     <= 1'b0;
         fault_oe_n_r   <= 1'b0;
         los_oe_n_r     <= 1'b0;
         present_oe_n_r <= 1'b0;
         sda_oe_n_r     <= 1'b1;
      end else begin
         pad_low_r      <= 1'b0;
         laser_en_r     <= laser_on_nxt;
         fault_oe_n_r   <= fault_lat_nxt;
         los_oe_n_r     <= los_now;
         present_oe_n_r <= 1'b0;
         sda_oe_n_r     <= ~sda_pull;
      end
   end

   assign laser_enable               = laser_en_r;
   assign laser_fault_o              = pad_low_r;
   assign laser_fault_oe_n           = fault_oe_n_r;
   assign rx_signal_lost_o           = pad_low_r;
   assign rx_signal_lost_oe_n        = los_oe_n_r;
   assign module_present_ground_o    = pad_low_r;
   assign module_present_ground_oe_n = present_oe_n_r;
   assign id_serial_data_o           = pad_low_r;
   assign id_serial_data_oe_n        = sda_oe_n_r;

   // Memory map: identification bytes, then diagnostic readings MSB first
   logic [7:0] id_mem [0:omc_pkg::ID_DEPTH-1];
   logic [7:0] diag_bytes [0:omc_pkg::DIAG_BYTES-1];
   wire  [15:0] diag_val [0:omc_pkg::DIAG_N-1];

   assign diag_val[0] = temp_reading;
   assign diag_val[1] = supply_reading;
   assign diag_val[2] = bias_reading;
   assign diag_val[3] = tx_power_reading;
   assign diag_val[4] = rx_power_reading;

   generate
      for (gi = 0; gi < omc_pkg::DIAG_N; gi++) begin : g_diag
         assign diag_bytes[2*gi]   = diag_val[gi][15:8];
         assign diag_bytes[2*gi+1] = diag_val[gi][7:0];
      end
   endgenerate

   logic [7:0] mem_addr;
   logic       mem_wr_en;
   logic [7:0] mem_wr_data;

   wire [7:0] diag_off = mem_addr - omc_pkg::DIAG_BASE;
   wire       in_id    = (mem_addr < omc_pkg::ID_DEPTH);
   wire       in_diag  = ~in_id & (diag_off < omc_pkg::DIAG_BYTES);
   wire [6:0] id_idx   = mem_addr[6:0];
   wire [7:0] mem_rd_data = in_id   ? id_mem[id_idx] :
                            in_diag ? diag_bytes[diag_off[3:0]] : 8'h00;

   // Identification bytes are host-writable storage
   always_ff @(posedge sys_clk) begin
      if (mem_wr_en && in_id) begin
         id_mem[id_idx] <= mem_wr_data;
      end
   end

   omc_twi_slave u_twi (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .scl_q       (filt_r[omc_pkg::SYN_SCL]),
      .sda_q       (filt_r[omc_pkg::SYN_SDA]),
      .sda_pull_low(sda_pull),
      .mem_addr    (mem_addr),
      .mem_rd_data (mem_rd_data),
      .mem_wr_en   (mem_wr_en),
      .mem_wr_data (mem_wr_data)
   );

endmodule

`default_nettype wire

// ---- inc/omc_pkg.sv ----
// Shared constants for the optical module control and status block
package omc_pkg;

   // Clock rate
   localparam int unsigned CLK_FREQ_MHZ = 200;

   // Least hold of the laser-off request that clears a latched fault
   localparam int unsigned T_RESET_US     = 10;
   localparam int unsigned RESET_HOLD_CYC = T_RESET_US * CLK_FREQ_MHZ;

   // Longest initialisation time after power-on or fault clear
   localparam int unsigned T_INIT_MS = 300;
   localparam int unsigned INIT_CYC  = T_INIT_MS * 1000 * CLK_FREQ_MHZ;

   // Synchroniser lanes
   localparam int unsigned SYN_N     = 6;
   localparam int unsigned SYN_TXOFF = 0;
   localparam int unsigned SYN_DRV   = 1;
   localparam int unsigned SYN_EOL   = 2;
   localparam int unsigned SYN_LOS   = 3;
   localparam int unsigned SYN_SCL   = 4;
   localparam int unsigned SYN_SDA   = 5;
   // Reset levels: laser-off request high, serial lines idle high
   localparam logic [SYN_N-1:0] SYN_RST = 6'h31;

   // Two-wire interface
   localparam logic [6:0] TWI_DEV_ADDR = 7'h50;
   localparam logic [7:0] ID_DEPTH     = 8'h80;
   localparam logic [7:0] DIAG_BASE    = 8'h80;
   localparam int unsigned DIAG_N      = 5;
   localparam logic [7:0] DIAG_BYTES   = 8'h0A;

   typedef enum logic [3:0] {
      TW_IDLE, TW_ADDR, TW_AACK, TW_WORD, TW_WACK, TW_WDATA, TW_DACK, TW_RDATA, TW_RACK
   } omc_tw_e;

   typedef enum logic {ST_INIT, ST_RUN} omc_st_e;

endpackage

// ---- hw/omc_twi_slave.sv ----
// Two-wire serial slave giving byte access to the module's memory map
`timescale 1ns/1ps
`default_nettype none

module omc_twi_slave (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Filtered serial lines
   input  wire logic       scl_q,
   input  wire logic       sda_q,
   output logic            sda_pull_low,
   // Memory access
   output logic [7:0]      mem_addr,
   input  wire logic [7:0] mem_rd_data,
   output logic            mem_wr_en,
   output logic [7:0]      mem_wr_data
);

   omc_pkg::omc_tw_e st_r;
   logic       scl_d_r;
   logic       sda_d_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] ptr_r;
   logic       rw_r;
   logic       more_r;
   logic       pull_r;
   logic       wr_r;

   wire start    = scl_q & scl_d_r & sda_d_r & ~sda_q;
   wire stop     = scl_q & scl_d_r & ~sda_d_r & sda_q;
   wire scl_rise = scl_q & ~scl_d_r;
   wire scl_fall = ~scl_q & scl_d_r;
   wire got8     = (cnt_r == 4'h8);
   wire addr_hit = (sh_r[7:1] == omc_pkg::TWI_DEV_ADDR);

   assign sda_pull_low = pull_r;
   assign mem_addr     = ptr_r;
   assign mem_wr_en    = wr_r;
   assign mem_wr_data  = sh_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= omc_pkg::TW_IDLE;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         ptr_r   <= 8'h00;
         rw_r    <= 1'b0;
         more_r  <= 1'b0;
         pull_r  <= 1'b0;
         wr_r    <= 1'b0;
      end else begin
         scl_d_r <= scl_q;
         sda_d_r <= sda_q;
         wr_r    <= 1'b0;
         if (start) begin
            st_r   <= omc_pkg::TW_ADDR;
            cnt_r  <= 4'h0;
            pull_r <= 1'b0;
         end else if (stop) begin
            st_r   <= omc_pkg::TW_IDLE;
            pull_r <= 1'b0;
         end else begin
            unique case (st_r)
               omc_pkg::TW_IDLE: begin
                  pull_r <= 1'b0;
               end
               omc_pkg::TW_ADDR, omc_pkg::TW_WORD, omc_pkg::TW_WDATA: begin
                  if (scl_rise && !got8) begin
                     sh_r  <= {sh_r[6:0], sda_q};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && got8) begin
                     cnt_r  <= 4'h0;
                     pull_r <= 1'b1;
                     if (st_r == omc_pkg::TW_ADDR) begin
                        // Only our device address is acknowledged
                        if (addr_hit) begin
                           rw_r <= sh_r[0];
                           st_r <= omc_pkg::TW_AACK;
                        end else begin
                           pull_r <= 1'b0;
                           st_r   <= omc_pkg::TW_IDLE;
                        end
                     end else if (st_r == omc_pkg::TW_WORD) begin
                        ptr_r <= sh_r;
                        st_r  <= omc_pkg::TW_WACK;
                     end else begin
                        wr_r <= 1'b1;
                        st_r <= omc_pkg::TW_DACK;
                     end
                  end
               end
               omc_pkg::TW_AACK, omc_pkg::TW_WACK, omc_pkg::TW_DACK: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (st_r == omc_pkg::TW_AACK && rw_r) begin
                        sh_r   <= mem_rd_data;
                        ptr_r  <= ptr_r + 8'h01;
                        pull_r <= ~mem_rd_data[7];
                        st_r   <= omc_pkg::TW_RDATA;
                     end else begin
                        // Pointer advances after each written byte
                        if (st_r == omc_pkg::TW_DACK) begin
                           ptr_r <= ptr_r + 8'h01;
                        end
                        pull_r <= 1'b0;
                        st_r   <= omc_pkg::TW_WDATA;
                        if (st_r == omc_pkg::TW_AACK) begin
                           st_r <= omc_pkg::TW_WORD;
                        end
                     end
                  end
               end
               omc_pkg::TW_RDATA: begin
                  if (scl_fall) begin
                     if (cnt_r == 4'h7) begin
                        pull_r <= 1'b0;
                        st_r   <= omc_pkg::TW_RACK;
                     end else begin
                        sh_r   <= {sh_r[6:0], 1'b0};
                        pull_r <= ~sh_r[6];
                        cnt_r  <= cnt_r + 4'h1;
                     end
                  end
               end
               omc_pkg::TW_RACK: begin
                  if (scl_rise) begin
                     more_r <= ~sda_q;
                  end else if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (more_r) begin
                        sh_r   <= mem_rd_data;
                        ptr_r  <= ptr_r + 8'h01;
                        pull_r <= ~mem_rd_data[7];
                        st_r   <= omc_pkg::TW_RDATA;
                     end else begin
                        st_r <= omc_pkg::TW_IDLE;
                     end
                  end
               end
               default: begin
                  st_r <= omc_pkg::TW_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ---- test/omc_props.sv ----
// Assertion checker on the optical module control ports
`timescale 1ns/1ps
`default_nettype none

module omc_props #(
   parameter int unsigned INIT_CYCLES = 50,
   parameter int unsigned HOLD_CYCLES = 20
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Laser control and detectors
   input wire logic laser_off_req,
   input wire logic laser_enable,
   input wire logic laser_drv_fail,
   input wire logic laser_end_of_life,
   input wire logic signal_absent_condition,
   // Pin drivers
   input wire logic laser_fault_o,
   input wire logic laser_fault_oe_n,
   input wire logic rx_signal_lost_o,
   input wire logic rx_signal_lost_oe_n,
   input wire logic module_present_ground_o,
   input wire logic module_present_ground_oe_n,
   input wire logic id_serial_data_o
);
   logic        fsrc;
   int unsigned fsrc_age_r;
   int unsigned run_cnt_r;
   int unsigned hi_cnt_r;
   int unsigned last_hold_r;

   assign fsrc = laser_drv_fail | laser_end_of_life;

   // Cycles since fault source, since reset, request high run length
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fsrc_age_r  <= 1000;
         run_cnt_r   <= 0;
         hi_cnt_r    <= 0;
         last_hold_r <= 0;
      end else begin
         fsrc_age_r  <= fsrc ? 0 : (fsrc_age_r < 1000 ? fsrc_age_r + 1 : fsrc_age_r);
         // Restarts when a fault clear sends the block back to init
         run_cnt_r   <= $fell(laser_fault_oe_n) ? 1 :
                        (run_cnt_r < INIT_CYCLES + 8) ? run_cnt_r + 1 : run_cnt_r;
         hi_cnt_r    <= laser_off_req ? (hi_cnt_r < 1000 ? hi_cnt_r + 1 : hi_cnt_r) : 0;
         last_hold_r <= (!laser_off_req && hi_cnt_r != 0) ? hi_cnt_r : last_hold_r;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   chk_req_laser_off: assert property (laser_off_req [*8] |-> !laser_enable)
      else $error("laser on under off request");
   chk_fault_laser_off: assert property (fsrc [*8] |-> !laser_enable)
      else $error("laser on during fault");
   chk_fault_cause: assert property ($rose(laser_fault_oe_n) |-> fsrc_age_r <= 8)
      else $error("fault shown without a cause");
   chk_fault_relatch: assert property (fsrc [*8] ##0 laser_fault_oe_n |=> laser_fault_oe_n)
      else $error("fault dropped while source present");
   chk_lost_set: assert property (signal_absent_condition [*7] |-> rx_signal_lost_oe_n)
      else $error("signal lost not shown");
   chk_lost_clear: assert property (!signal_absent_condition [*7] |-> !rx_signal_lost_oe_n)
      else $error("signal lost shown without cause");
   chk_open_drain: assert property (!(laser_fault_o | rx_signal_lost_o | id_serial_data_o))
      else $error("status pin driven high");
   chk_present_gnd: assert property (!module_present_ground_oe_n && !module_present_ground_o)
      else $error("presence pin not grounded");
   chk_init_hold: assert property (laser_enable |-> run_cnt_r >= INIT_CYCLES)
      else $error("laser on during start-up");
   chk_enable_cause: assert property ($rose(laser_enable) |-> !laser_fault_oe_n && $past(laser_off_req, 4) == 1'b0)
      else $error("laser on without cause");
   chk_clear_hold: assert property ($fell(laser_fault_oe_n) |-> last_hold_r >= HOLD_CYCLES)
      else $error("fault cleared by short request");

   cov_fault: cover property ($rose(laser_fault_oe_n));
   cov_clear: cover property ($fell(laser_fault_oe_n));
   cov_laser_on: cover property ($rose(laser_enable));
endmodule

`default_nettype wire

// ---- test/omc_host_model.sv ----
// Host-side model: pad pull-ups, status synchronisers, two-wire master
`timescale 1ns/1ps
`default_nettype none

module omc_host_model (
   // Clock
   input  wire logic sys_clk,
   // Request pad control
   input  wire logic req_drive,
   input  wire logic req_level,
   output logic      laser_off_req,
   // Module status pins
   input  wire logic laser_fault_o,
   input  wire logic laser_fault_oe_n,
   input  wire logic rx_signal_lost_o,
   input  wire logic rx_signal_lost_oe_n,
   input  wire logic module_present_ground_o,
   input  wire logic module_present_ground_oe_n,
   // Two-wire pins
   input  wire logic id_serial_data_o,
   input  wire logic id_serial_data_oe_n,
   output logic      id_serial_clock,
   output logic      id_serial_data_i,
   // Synchronised host view
   output logic      fault_seen,
   output logic      lost_seen,
   output logic      present_seen
);
   logic       sda_rel_r;
   logic [2:0] sy1_r;

   assign laser_off_req = req_drive ? req_level : 1'b1;
   // Released wires float high through the pull-ups
   assign id_serial_data_i = sda_rel_r & (id_serial_data_oe_n | id_serial_data_o);

   always_ff @(posedge sys_clk) begin
      sy1_r        <= {laser_fault_oe_n | laser_fault_o, rx_signal_lost_oe_n | rx_signal_lost_o,
                       module_present_ground_oe_n | module_present_ground_o};
      fault_seen   <= sy1_r[2];
      lost_seen    <= sy1_r[1];
      present_seen <= sy1_r[0];
   end

   initial begin
      sda_rel_r       = 1'b1;
      id_serial_clock = 1'b1;
   end

   task automatic q();
      repeat (10) @(negedge sys_clk);
   endtask

   task automatic twi_start();
      sda_rel_r = 1'b1;
      q();
      id_serial_clock = 1'b1;
      q();
      sda_rel_r = 1'b0;
      q();
      id_serial_clock = 1'b0;
      q();
   endtask

   task automatic twi_stop();
      sda_rel_r = 1'b0;
      q();
      id_serial_clock = 1'b1;
      q();
      sda_rel_r = 1'b1;
      q();
   endtask

   task automatic twi_bit(input logic b, output logic r);
      sda_rel_r = b;
      q();
      id_serial_clock = 1'b1;
      q();
      r = id_serial_data_i;
      q();
      id_serial_clock = 1'b0;
      q();
   endtask

   task automatic twi_byte(input logic [7:0] tx, input logic a9, output logic [7:0] rx,
                           output logic r9);
      for (int i = 7; i >= 0; i--) begin
         twi_bit(tx[i], rx[i]);
      end
      twi_bit(a9, r9);
   endtask
endmodule

`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the optical module control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int unsigned INIT_N = 50;
   localparam int unsigned HOLD_N = 20;

   logic        sys_clk, rst_n, req_drive, req_level, drv_fail, eol, sig_abs;
   logic        laser_off_req, laser_enable, f_o, f_oe_n, l_o, l_oe_n, p_o, p_oe_n;
   logic        scl, sda_i, sda_o, sda_oe_n, ack;
   logic [15:0] rdg [5];
   logic [7:0]  rbuf [10];
   logic [7:0]  junk;
   int          n_errors, n_tests;

   omc_ctrl #(.INIT_CYCLES(INIT_N), .HOLD_CYCLES(HOLD_N)) i_omc_ctrl (
      .sys_clk(sys_clk), .rst_n(rst_n), .laser_off_req(laser_off_req),
      .laser_enable(laser_enable), .laser_drv_fail(drv_fail), .laser_end_of_life(eol),
      .signal_absent_condition(sig_abs), .temp_reading(rdg[0]), .supply_reading(rdg[1]),
      .bias_reading(rdg[2]), .tx_power_reading(rdg[3]), .rx_power_reading(rdg[4]),
      .laser_fault_o(f_o), .laser_fault_oe_n(f_oe_n), .rx_signal_lost_o(l_o),
      .rx_signal_lost_oe_n(l_oe_n), .module_present_ground_o(p_o),
      .module_present_ground_oe_n(p_oe_n), .id_serial_clock(scl),
      .id_serial_data_i(sda_i), .id_serial_data_o(sda_o), .id_serial_data_oe_n(sda_oe_n));

   omc_host_model i_omc_host_model (
      .sys_clk(sys_clk), .req_drive(req_drive), .req_level(req_level),
      .laser_off_req(laser_off_req), .laser_fault_o(f_o), .laser_fault_oe_n(f_oe_n),
      .rx_signal_lost_o(l_o), .rx_signal_lost_oe_n(l_oe_n), .module_present_ground_o(p_o),
      .module_present_ground_oe_n(p_oe_n), .id_serial_data_o(sda_o),
      .id_serial_data_oe_n(sda_oe_n), .id_serial_clock(scl), .id_serial_data_i(sda_i),
      .fault_seen(), .lost_seen(), .present_seen());

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic clear_fault(input int hold);
      req_level = 1'b1;
      cyc(hold);
      req_level = 1'b0;
      cyc(12);
   endtask

   task automatic addr_phase(input logic [7:0] dev, input logic [7:0] a);
      i_omc_host_model.twi_start();
      i_omc_host_model.twi_byte(dev, 1'b1, junk, ack);
      chk_bit(ack, 1'b0);
      i_omc_host_model.twi_byte(a, 1'b1, junk, ack);
      chk_bit(ack, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input int n);
      addr_phase(8'hA0, a);
      i_omc_host_model.twi_start();
      i_omc_host_model.twi_byte(8'hA1, 1'b1, junk, ack);
      chk_bit(ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_omc_host_model.twi_byte(8'hFF, i == n - 1, rbuf[i], ack);
      end
      i_omc_host_model.twi_stop();
   endtask

   initial begin
      n_errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      req_drive = 1'b1;
      req_level = 1'b0;
      drv_fail = 1'b0;
      eol = 1'b0;
      sig_abs = 1'b0;
      for (int i = 0; i < 5; i++) rdg[i] = 16'h1357 + 16'(i * 16'h1111);
      cyc(8);
      rst_n = 1'b1;
      cyc(20);
      chk_bit(laser_enable, 1'b0);
      chk_bit(i_omc_host_model.present_seen, 1'b0);
      cyc(INIT_N);
      chk_bit(laser_enable, 1'b1);
      // Request driven high, then pad left floating
      for (int m = 0; m < 2; m++) begin
         if (m == 0) req_level = 1'b1;
         else req_drive = 1'b0;
         cyc(12);
         chk_bit(laser_enable, 1'b0);
         req_level = 1'b0;
         req_drive = 1'b1;
         cyc(12);
         chk_bit(laser_enable, 1'b1);
      end
      sig_abs = 1'b1;
      cyc(12);
      chk_bit(i_omc_host_model.lost_seen, 1'b1);
      sig_abs = 1'b0;
      cyc(12);
      chk_bit(i_omc_host_model.lost_seen, 1'b0);
      // Each fault source: latch, refused short clear, good clear
      for (int s = 0; s < 2; s++) begin
         if (s == 0) drv_fail = 1'b1;
         else eol = 1'b1;
         cyc(10);
         drv_fail = 1'b0;
         eol = 1'b0;
         cyc(5);
         chk_bit(i_omc_host_model.fault_seen, 1'b1);
         chk_bit(laser_enable, 1'b0);
         clear_fault(HOLD_N / 2);
         chk_bit(i_omc_host_model.fault_seen, 1'b1);
         clear_fault(HOLD_N + 10);
         chk_bit(i_omc_host_model.fault_seen, 1'b0);
         chk_bit(laser_enable, 1'b0);
         cyc(INIT_N + 5);
         chk_bit(laser_enable, 1'b1);
      end
      drv_fail = 1'b1;
      cyc(12);
      clear_fault(HOLD_N + 10);
      chk_bit(i_omc_host_model.fault_seen, 1'b1);
      chk_bit(laser_enable, 1'b0);
      drv_fail = 1'b0;
      clear_fault(HOLD_N + 10);
      cyc(INIT_N + 5);
      chk_bit(laser_enable, 1'b1);
      // Identification write and read back, then diagnostic readings read
      addr_phase(8'hA0, 8'h05);
      i_omc_host_model.twi_byte(8'hA5, 1'b1, junk, ack);
      chk_bit(ack, 1'b0);
      i_omc_host_model.twi_stop();
      rd(8'h05, 1);
      chk_byte(rbuf[0], 8'hA5);
      rd(omc_pkg::DIAG_BASE, 10);
      for (int i = 0; i < 10; i++) begin
         chk_byte(rbuf[i], i[0] ? rdg[i / 2][7:0] : rdg[i / 2][15:8]);
      end
      // Foreign device address gets no answer
      i_omc_host_model.twi_start();
      i_omc_host_model.twi_byte(8'hA2, 1'b1, junk, ack);
      chk_bit(ack, 1'b1);
      i_omc_host_model.twi_stop();
      results();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      results();
   end
endmodule

bind omc_ctrl omc_props #(.INIT_CYCLES(INIT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) i_omc_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .laser_off_req(laser_off_req),
   .laser_enable(laser_enable), .laser_drv_fail(laser_drv_fail),
   .laser_end_of_life(laser_end_of_life), .signal_absent_condition(signal_absent_condition),
   .laser_fault_o(laser_fault_o), .laser_fault_oe_n(laser_fault_oe_n),
   .rx_signal_lost_o(rx_signal_lost_o), .rx_signal_lost_oe_n(rx_signal_lost_oe_n),
   .module_present_ground_o(module_present_ground_o),
   .module_present_ground_oe_n(module_present_ground_oe_n),
   .id_serial_data_o(id_serial_data_o));

`default_nettype wire
